// File: dri_defs.svh
// constants for the read-back link: timing, addresses, fields and register map
`ifndef DRI_DEFS_SVH
`define DRI_DEFS_SVH
`define DRI_CLK_NS 8
`define DRI_QTR_NS 100
`define DRI_QTR_CYC (`DRI_QTR_NS / `DRI_CLK_NS)
`define DRI_ADDR_PREFIX 5'h13
`define DRI_RW_WRITE 1'h0
`define DRI_RW_READ 1'h1
`define DRI_PWB_FILL 6'h3f
`define DRI_NCHAN 4
`define DRI_BYTE_BITS 4'h8
`define DRI_LAST_PD1 2'h2
`define DRI_LAST_PD0 2'h1
`define DRI_CB_PD 0
`define DRI_CB_CHAN 2:1
`define DRI_REG_CTRL 8'h00
`define DRI_REG_STATUS 8'h04
`define DRI_REG_RXDATA 8'h08
`define DRI_CTRL_GO 0
`define DRI_CTRL_APIN 2:1
`define DRI_CTRL_EXT 4:3
`define DRI_CTRL_LOAD 6:5
`define DRI_CTRL_CHAN 8:7
`define DRI_CTRL_PD 9
`define DRI_CTRL_RSFIN 10
`define DRI_ST_BUSY 0
`define DRI_ST_NACK 1
`define DRI_ST_RXAV 2
`define DRI_RX_VALID 8
`define DRI_FIFO_W 8
`define DRI_FIFO_D 32
`endif

// File: dri_pkg.sv
// types for the read-back link: sequencer states for the controller, the rest for the converter
package dri_pkg;
  typedef enum logic [1:0] {dri_out_normal, dri_out_hiz, dri_out_1k, dri_out_100k} dri_out_e;
  typedef enum logic [2:0] {st_idle, st_addr, st_ack, st_ctrl, st_hold, st_tx, st_mack} dri_dev_e;
  typedef enum logic [2:0] {sq_idle, sq_s, sq_aw, sq_ctrl, sq_sr, sq_ar, sq_rd, sq_fin} dri_sq_e;
  typedef struct packed {
    logic pd;
    logic [1:0] mode;
    logic [15:0] data;
  } dri_chan_s;
endpackage

// File: dri_bus_if.sv
// two-wire bus between the controller and the converter, open-drain resolved
`timescale 1ns/1ps
interface dri_bus_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // a driver can only pull low; released lines float high
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
  modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// File: dri_device.sv
// converter end: slave receiver of address and control, slave transmitter of read-back
`timescale 1ns/1ps
`include "dri_defs.svh"

// Overview of operation
// - start, address 10011 plus pins, write bit
// - control byte acknowledged; ext, load, channel, flag
// - repeated start, read address, device transmits
// - flag clear: high byte then low byte
// - flag set: status, high, low bytes
// - status byte: mode bits, then six ones
// - channel chosen by control channel bits
// - data sent most significant bit first
// - master acks all but final byte
// - master ends with stop or repeated start
// - repeated start preferred to keep bus
// - mode bits map to output termination
module dri_device (
  input wire logic clk,
  input wire logic reset,
  dri_bus_if.device bus,
  input wire logic [1:0] addr_pin,
  input wire logic load_valid,
  input wire logic [1:0] load_chan,
  input wire logic load_pd,
  input wire logic [1:0] load_mode,
  input wire logic [15:0] load_data,
  output logic [7:0] last_ctrl,
  output logic read_active,
  output logic early_nack,
  output dri_pkg::dri_out_e out_state [`DRI_NCHAN]
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic dri_pkg::dri_out_e mode_of(input dri_pkg::dri_chan_s c);
    dri_pkg::dri_out_e m;
    m = dri_pkg::dri_out_normal;
    if (c.pd) begin
      unique case (c.mode)
        2'h1: m = dri_pkg::dri_out_1k;
        2'h2: m = dri_pkg::dri_out_100k;
        default: m = dri_pkg::dri_out_hiz;
      endcase
    end
    return m;
  endfunction

  function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic pdf, input dri_pkg::dri_chan_s c);
    logic [1:0] k;
    logic [7:0] b;
    k = pdf ? idx : 2'(idx + 2'h1);
    unique case (k)
      2'h0: b = {c.mode, `DRI_PWB_FILL};
      2'h1: b = c.data[15:8];
      default: b = c.data[7:0];
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic rise, fall, start_c, stop_c;

  always_ff @(posedge clk) begin
    if (reset) begin
      {scl_s3, scl_s2, scl_s1} <= 3'h7;
      {sda_s3, sda_s2, sda_s1} <= 3'h7;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, bus.scl};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, bus.sda};
    end
  end

  assign rise = scl_s2 && !scl_s3;
  assign fall = !scl_s2 && scl_s3;
  // sda moving while scl stays high marks start and stop
  assign start_c = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_c = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // ----------------------------------------
  // channel storage
  // ----------------------------------------
  dri_pkg::dri_chan_s chan [`DRI_NCHAN];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `DRI_NCHAN; i++) begin
        chan[i] <= '0;
      end
    end else if (load_valid) begin
      if (load_pd) begin
        chan[load_chan].pd <= 1'h1;
        chan[load_chan].mode <= load_mode;
      end else begin
        chan[load_chan].pd <= 1'h0;
        chan[load_chan].data <= load_data;
      end
    end
  end

  for (genvar g = 0; g < `DRI_NCHAN; g++) begin : g_mode
    always_ff @(posedge clk) begin
      if (reset) begin
        out_state[g] <= dri_pkg::dri_out_normal;
      end else begin
        out_state[g] <= mode_of(chan[g]);
      end
    end
  end

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  dri_pkg::dri_dev_e st, after_st;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [1:0] idx;
  logic mack_ok;
  logic sda_pull;
  logic [1:0] next_idx;
  logic [1:0] last_idx;
  logic [7:0] next_tx;
  logic addr_hit;

  assign next_idx = (st == dri_pkg::st_ack) ? 2'h0 : 2'(idx + 2'h1);
  assign last_idx = last_ctrl[`DRI_CB_PD] ? `DRI_LAST_PD1 : `DRI_LAST_PD0;
  assign next_tx = tx_byte(next_idx, last_ctrl[`DRI_CB_PD], chan[last_ctrl[`DRI_CB_CHAN]]);
  assign addr_hit = sh[7:1] == {`DRI_ADDR_PREFIX, addr_pin};

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= dri_pkg::st_idle;
      after_st <= dri_pkg::st_idle;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      idx <= 2'h0;
      mack_ok <= 1'h0;
      sda_pull <= 1'h0;
      last_ctrl <= 8'h00;
    end else if (start_c) begin
      // a start or repeated start always restarts address reception
      st <= dri_pkg::st_addr;
      cnt <= 4'h0;
      sda_pull <= 1'h0;
    end else if (stop_c) begin
      st <= dri_pkg::st_idle;
      sda_pull <= 1'h0;
    end else if (rise) begin
      unique case (st)
        dri_pkg::st_addr, dri_pkg::st_ctrl: begin
          sh <= {sh[6:0], sda_s2};
          cnt <= cnt + 4'h1;
        end
        dri_pkg::st_tx: begin
          cnt <= cnt + 4'h1;
        end
        dri_pkg::st_mack: begin
          mack_ok <= !sda_s2;
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      unique case (st)
        dri_pkg::st_addr: begin
          if (cnt == `DRI_BYTE_BITS) begin
            cnt <= 4'h0;
            if (addr_hit) begin
              sda_pull <= 1'h1;
              st <= dri_pkg::st_ack;
              after_st <= (sh[0] == `DRI_RW_READ) ? dri_pkg::st_tx : dri_pkg::st_ctrl;
            end else begin
              st <= dri_pkg::st_idle;
            end
          end
        end
        dri_pkg::st_ctrl: begin
          if (cnt == `DRI_BYTE_BITS) begin
            cnt <= 4'h0;
            last_ctrl <= sh;
            sda_pull <= 1'h1;
            st <= dri_pkg::st_ack;
            after_st <= dri_pkg::st_hold;
          end
        end
        dri_pkg::st_ack: begin
          st <= after_st;
          if (after_st == dri_pkg::st_tx) begin
            idx <= next_idx;
            tx <= next_tx;
            sda_pull <= !next_tx[7];
          end else begin
            sda_pull <= 1'h0;
          end
        end
        dri_pkg::st_tx: begin
          if (cnt == `DRI_BYTE_BITS) begin
            cnt <= 4'h0;
            sda_pull <= 1'h0;
            st <= dri_pkg::st_mack;
          end else begin
            sda_pull <= !tx[3'(4'h7 - cnt)];
          end
        end
        dri_pkg::st_mack: begin
          if (mack_ok && idx != last_idx) begin
            idx <= next_idx;
            tx <= next_tx;
            sda_pull <= !next_tx[7];
            st <= dri_pkg::st_tx;
          end else begin
            // nack, or extra ack past the last byte: stop sending
            st <= dri_pkg::st_idle;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      read_active <= 1'h0;
    end else begin
      read_active <= (st == dri_pkg::st_tx) || (st == dri_pkg::st_mack);
    end
  end

  // master gave up before the last byte; sticky until the next read address
  always_ff @(posedge clk) begin
    if (reset) begin
      early_nack <= 1'h0;
    end else if (fall && st == dri_pkg::st_mack && !mack_ok && idx != last_idx) begin
      early_nack <= 1'h1;
    end else if (fall && st == dri_pkg::st_ack && after_st == dri_pkg::st_tx) begin
      early_nack <= 1'h0;
    end
  end

  assign bus.d_sda_o = 1'h0;
  assign bus.d_sda_oe = sda_pull;

endmodule

// File: dri_master.sv
// controller end: APB register slave, bit engine on the two-wire bus, receive FIFO
`timescale 1ns/1ps
`include "dri_defs.svh"

// ----------------------------------------
// receive FIFO
// ----------------------------------------
module dri_fifo #(
  parameter int WIDTH = `DRI_FIFO_W,
  parameter int DEPTH = `DRI_FIFO_D
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] cnt;
  logic push, pop;

  assign in_ready = cnt != (AW + 1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= push ? AW'(wp + 1'h1) : wp;
      rp <= pop ? AW'(rp + 1'h1) : rp;
      cnt <= (AW + 1)'(cnt + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop});
    end
  end
endmodule

// ----------------------------------------
// controller
// ----------------------------------------
module dri_master (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dri_bus_if.master bus
);
  function automatic logic mapped(input logic [7:0] a);
    return a == `DRI_REG_CTRL || a == `DRI_REG_STATUS || a == `DRI_REG_RXDATA;
  endfunction

  logic access;
  logic [10:1] cfg;
  logic busy, nack_err;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [7:0] rx, fifo_out_data;
  logic sda_s1, sda_s2;
  dri_pkg::dri_sq_e sq;
  logic [1:0] ph, idx;
  logic [3:0] bcnt;
  logic [7:0] qcnt, sh;
  logic ackd, fin_rs, run, tick, writing, last_rd, sda_low;
  logic scl_pull, sda_pull;
  logic go;

  assign access = psel && penable && pready;
  assign go = access && pwrite && paddr == `DRI_REG_CTRL && pwdata[`DRI_CTRL_GO] && !busy;

  // ----------------------------------------
  // APB slave: answer in the first access cycle
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        pslverr <= !mapped(paddr);
        prdata <= 32'h0;
        if (paddr == `DRI_REG_CTRL) begin
          prdata[10:1] <= cfg;
        end else if (paddr == `DRI_REG_STATUS) begin
          prdata[`DRI_ST_BUSY] <= busy;
          prdata[`DRI_ST_NACK] <= nack_err;
          prdata[`DRI_ST_RXAV] <= fifo_out_valid;
        end else if (paddr == `DRI_REG_RXDATA) begin
          prdata[`DRI_RX_VALID:0] <= {fifo_out_valid, fifo_out_data};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= '0;
    end else if (go) begin
      cfg <= pwdata[10:1];
    end
  end

  // ----------------------------------------
  // bit engine: four quarter phases per slot
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      {sda_s2, sda_s1} <= 2'h3;
    end else begin
      {sda_s2, sda_s1} <= {sda_s1, bus.sda};
    end
  end

  assign writing = sq == dri_pkg::sq_aw || sq == dri_pkg::sq_ctrl || sq == dri_pkg::sq_ar;
  assign last_rd = idx == (cfg[`DRI_CTRL_PD] ? `DRI_LAST_PD1 : `DRI_LAST_PD0);
  // a full FIFO holds scl low before the next read byte
  assign run = sq != dri_pkg::sq_idle && !(sq == dri_pkg::sq_rd && bcnt == 4'h0 && ph == 2'h0 && !fifo_in_ready);
  assign tick = run && qcnt == 8'(`DRI_QTR_CYC - 1);
  assign sda_low = (bcnt == `DRI_BYTE_BITS) ? (sq == dri_pkg::sq_rd && !last_rd) : (writing && !sh[3'(4'h7 - bcnt)]);

  always_ff @(posedge clk) begin
    if (reset || !run) begin
      qcnt <= 8'h0;
    end else begin
      qcnt <= tick ? 8'h0 : 8'(qcnt + 8'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sq <= dri_pkg::sq_idle;
      ph <= 2'h0;
      bcnt <= 4'h0;
      idx <= 2'h0;
      sh <= 8'h0;
      rx <= 8'h0;
      ackd <= 1'h0;
      fin_rs <= 1'h0;
      busy <= 1'h0;
      scl_pull <= 1'h0;
      sda_pull <= 1'h0;
      fifo_in_valid <= 1'h0;
    end else begin
      fifo_in_valid <= 1'h0;
      if (go) begin
        sq <= dri_pkg::sq_s;
        busy <= 1'h1;
        ph <= 2'h0;
      end else if (tick) begin
        ph <= 2'(ph + 2'h1);
        unique case (ph)
          2'h0: begin
            if (sq == dri_pkg::sq_fin && !fin_rs) begin
              sda_pull <= 1'h1;
            end else if (sq == dri_pkg::sq_s || sq == dri_pkg::sq_sr || sq == dri_pkg::sq_fin) begin
              sda_pull <= 1'h0;
            end else begin
              sda_pull <= sda_low;
            end
          end
          2'h1: begin
            scl_pull <= 1'h0;
          end
          2'h2: begin
            if (sq == dri_pkg::sq_s || sq == dri_pkg::sq_sr || (sq == dri_pkg::sq_fin && fin_rs)) begin
              sda_pull <= 1'h1;
            end else if (sq == dri_pkg::sq_fin) begin
              sda_pull <= 1'h0;
            end else if (bcnt == `DRI_BYTE_BITS) begin
              ackd <= !sda_s2;
            end else begin
              rx <= {rx[6:0], sda_s2};
            end
          end
          default: begin
            scl_pull <= sq != dri_pkg::sq_fin || fin_rs;
            bcnt <= 4'h0;
            unique case (sq)
              dri_pkg::sq_s: begin
                sq <= dri_pkg::sq_aw;
                sh <= {`DRI_ADDR_PREFIX, cfg[`DRI_CTRL_APIN], `DRI_RW_WRITE};
              end
              dri_pkg::sq_sr: begin
                sq <= dri_pkg::sq_ar;
                sh <= {`DRI_ADDR_PREFIX, cfg[`DRI_CTRL_APIN], `DRI_RW_READ};
              end
              dri_pkg::sq_fin: begin
                sq <= dri_pkg::sq_idle;
                busy <= 1'h0;
              end
              default: begin
                if (bcnt != `DRI_BYTE_BITS) begin
                  bcnt <= 4'(bcnt + 4'h1);
                  sq <= sq;
                end else if (sq == dri_pkg::sq_rd) begin
                  fifo_in_valid <= 1'h1;
                  idx <= 2'(idx + 2'h1);
                  sq <= last_rd ? dri_pkg::sq_fin : dri_pkg::sq_rd;
                end else if (!ackd) begin
                  fin_rs <= 1'h0;
                  sq <= dri_pkg::sq_fin;
                end else if (sq == dri_pkg::sq_aw) begin
                  sq <= dri_pkg::sq_ctrl;
                  sh <= {cfg[`DRI_CTRL_EXT], cfg[`DRI_CTRL_LOAD], 1'h0, cfg[`DRI_CTRL_CHAN], cfg[`DRI_CTRL_PD]};
                end else if (sq == dri_pkg::sq_ctrl) begin
                  sq <= dri_pkg::sq_sr;
                end else begin
                  idx <= 2'h0;
                  sq <= dri_pkg::sq_rd;
                end
              end
            endcase
          end
        endcase
      end
      if (go) begin
        fin_rs <= pwdata[`DRI_CTRL_RSFIN];
      end
    end
  end

  // set wins over the software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      nack_err <= 1'h0;
    end else if (tick && ph == 2'h3 && writing && bcnt == `DRI_BYTE_BITS && !ackd) begin
      nack_err <= 1'h1;
    end else if (access && pwrite && paddr == `DRI_REG_STATUS && pwdata[`DRI_ST_NACK]) begin
      nack_err <= 1'h0;
    end
  end

  dri_fifo #(.WIDTH(`DRI_FIFO_W), .DEPTH(`DRI_FIFO_D)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_data(rx),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(access && !pwrite && paddr == `DRI_REG_RXDATA)
  );

  assign bus.scl_o = 1'h0;
  assign bus.scl_oe = scl_pull;
  assign bus.m_sda_o = 1'h0;
  assign bus.m_sda_oe = sda_pull;
endmodule

// File: dri_bus_assertions.sv
// bus checker for the two-wire read-back link
`timescale 1ns/1ps

module dri_bus_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------
  // bit and byte tracking from the wires
  // ----------------------------------------
  logic scl_q, sda_q, rise, rd;
  logic [3:0] bitn;
  logic [2:0] bytei;
  logic [2:0] nlast;
  logic [7:0] sh;
  logic [7:0] ctrl;
  assign rise = scl && !scl_q;
  assign nlast = ctrl[0] ? 3'h3 : 3'h2;
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // any start restarts the count, so repeated starts realign it
  always_ff @(posedge clk) begin
    if (reset || (scl && scl_q && sda_q && !sda)) begin
      bitn <= 4'h0;
      bytei <= 3'h0;
    end else if (rise && bitn == 4'h8) begin
      bitn <= 4'h0;
      bytei <= bytei + 3'h1;
    end else if (rise) begin
      bitn <= bitn + 4'h1;
      sh <= {sh[6:0], sda};
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rd <= 1'b0;
      ctrl <= 8'h00;
    end else if (rise && bitn == 4'h8 && bytei == 3'h0) begin
      rd <= sh[0];
    end else if (rise && bitn == 4'h8 && bytei == 3'h1 && !rd) begin
      ctrl <= sh;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  dev_stable_a: assert property (scl && scl_q |-> $stable(d_sda_oe))
    else $error("device sda changed while scl high");
  addr_match_a: assert property (rise && bitn == 4'h8 && bytei == 3'h0 && d_sda_oe |-> sh[7:3] == 5'h13)
    else $error("device acked a foreign address");
  ctrl_ack_a: assert property ($fell(scl) && bitn == 4'h8 && bytei == 3'h1 && !rd |-> ##[1:16] d_sda_oe)
    else $error("control byte not acked");
  read_ack_a: assert property ($fell(scl) && bitn == 4'h8 && bytei == 3'h0 && sh[7:3] == 5'h13 && sh[0]
    |-> ##[1:16] d_sda_oe)
    else $error("read address not acked");
  read_drive_a: assert property (rise && bitn != 4'h8 && d_sda_oe |-> rd)
    else $error("device drove data outside a read");
  mack_free_a: assert property (rise && bitn == 4'h8 && rd && bytei != 3'h0 |-> !d_sda_oe)
    else $error("device held sda in master ack slot");
  pd_fill_a: assert property (rise && rd && ctrl[0] && bytei == 3'h1 && bitn >= 4'h2 && bitn <= 4'h7 |-> sda)
    else $error("status byte low bits not ones");
  byte_count_a: assert property (rd && bytei > nlast |-> !d_sda_oe)
    else $error("device sent past the last byte");
  master_ack_a: assert property (rise && bitn == 4'h8 && rd && bytei != 3'h0 |-> sda == (bytei == nlast))
    else $error("master ack or nack misplaced");
  cover property (rise && bitn == 4'h8 && bytei == 3'h0 && sda);
  cover property (rise && rd && ctrl[0] && bytei == 3'h1 && bitn == 4'h7);
  cover property (scl && scl_q && sda_q && !sda && bytei != 3'h0);
endmodule

// File: dac_i2c_readback_tb.sv
// bench: controller and converter joined over the bus, fifo exercised through the controller
`timescale 1ns/1ps
`include "dri_defs.svh"

module dac_i2c_readback_tb;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0] addr_pin, load_chan, load_mode;
  logic load_valid, load_pd, read_active, early_nack;
  logic [15:0] load_data;
  logic [7:0] last_ctrl;
  dri_pkg::dri_out_e out_state [`DRI_NCHAN];
  int fails, n_tests;
  logic [15:0] dat [4];
  logic [1:0] mode [4];
  // bytes the device should return, oldest first
  logic [7:0] exq [40];
  int nq, hq;
  dri_bus_if bus ();
  dri_master u_dri_master (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  dri_device u_dri_device (.clk(clk), .reset(reset), .bus(bus), .addr_pin(addr_pin), .load_valid(load_valid),
    .load_chan(load_chan), .load_pd(load_pd), .load_mode(load_mode), .load_data(load_data),
    .last_ctrl(last_ctrl), .read_active(read_active), .early_nack(early_nack), .out_state(out_state));
  dri_bus_assertions u_dri_bus_assertions (.clk(clk), .reset(reset), .d_sda_oe(bus.d_sda_oe), .scl(bus.scl),
    .sda(bus.sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic dri_pkg::dri_out_e exp_out(input logic p, input logic [1:0] m);
    if (!p) return dri_pkg::dri_out_normal;
    if (m == 2'h1) return dri_pkg::dri_out_1k;
    if (m == 2'h2) return dri_pkg::dri_out_100k;
    return dri_pkg::dri_out_hiz;
  endfunction
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // the request stands until pready is seen; the slave answers on its own timing
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    q = {prdata[31:1], prdata[0]};
    if (a == 8'h0c) q = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic load(input logic [1:0] c, input logic p, input logic [1:0] m, input logic [15:0] d);
    load_valid <= 1'b1;
    load_chan <= c;
    load_pd <= p;
    load_mode <= m;
    load_data <= d;
    @(posedge clk);
    load_valid <= 1'b0;
    @(posedge clk);
    // out_state is registered one edge after the channel store
    @(posedge clk);
  endtask
  task automatic wait_idle(output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0) begin
      if (n++ > 2000) begin
        fails++;
        wrap_up();
      end
      apb(1'b0, `DRI_REG_STATUS, 32'h0, q);
    end
  endtask
  // queues the bytes it expects; wt low leaves the read running
  task automatic readback(input logic [1:0] pins, input logic [1:0] c, input logic p, input logic fin,
    input logic wt);
    logic [31:0] q, r;
    r = rnd();
    apb(1'b1, `DRI_REG_CTRL, {21'h0, fin, p, c, r[3:2], r[1:0], pins, 1'b1}, q);
    apb(1'b0, `DRI_REG_STATUS, 32'h0, q);
    chk("busy", 32'h1, {31'h0, q[0]});
    if (pins === addr_pin) begin
      if (p) exq[nq++] = {mode[c], 6'h3f};
      exq[nq++] = dat[c][15:8];
      exq[nq++] = dat[c][7:0];
    end
    if (wt) begin
      wait_idle(q);
      if (pins === addr_pin) begin
        chk("status_done", 32'h4, q);
        chk("last_ctrl", {24'h0, r[1:0], r[3:2], 1'b0, c, p}, {24'h0, last_ctrl});
        apb(1'b0, `DRI_REG_CTRL, 32'h0, q);
        chk("ctrl_reg", {21'h0, fin, p, c, r[3:2], r[1:0], pins, 1'b0}, q);
      end else begin
        chk("status_nack", 32'h2, q);
        apb(1'b1, `DRI_REG_STATUS, 32'h2, q);
        apb(1'b0, `DRI_REG_STATUS, 32'h0, q);
        chk("nack_clear", 32'h0, q);
      end
    end
  endtask
  task automatic drain(input int k);
    logic [31:0] q;
    repeat (k) begin
      apb(1'b0, `DRI_REG_RXDATA, 32'h0, q);
      chk("rx_byte", {23'h0, 1'b1, exq[hq]}, q);
      hq++;
    end
  endtask
  task automatic idle_chk();
    logic [31:0] q;
    apb(1'b0, `DRI_REG_RXDATA, 32'h0, q);
    chk("rx_empty", 32'h0, {31'h0, q[8]});
    chk("read_idle", 32'h0, {30'h0, read_active, early_nack});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    int i;
    fails = 0;
    n_tests = 0;
    seed = 32'h00005673;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {load_valid, load_chan, load_pd, load_mode, load_data} = '0;
    nq = 0;
    hq = 0;
    q = rnd();
    addr_pin = q[1:0];
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, `DRI_REG_STATUS, 32'h0, q);
    chk("status_reset", 32'h0, q);
    apb(1'b0, 8'h0c, 32'h0, q);
    chk("unmapped_err", 32'h1, q);
    for (i = 0; i < 4; i++) begin
      q = rnd();
      dat[i] = q[15:0];
      load(i[1:0], 1'b0, 2'h0, dat[i]);
      chk("out_normal", 32'(exp_out(1'b0, 2'h0)), 32'(out_state[i]));
      mode[i] = i[1:0];
      load(i[1:0], 1'b1, mode[i], 16'h0000);
      chk("out_pd", 32'(exp_out(1'b1, mode[i])), 32'(out_state[i]));
    end
    readback(addr_pin ^ 2'h1, 2'h0, 1'b0, 1'b0, 1'b1);
    idle_chk();
    q = rnd();
    readback(addr_pin, q[1:0], 1'b1, 1'b0, 1'b1);
    drain(3);
    idle_chk();
    readback(addr_pin, q[3:2], 1'b0, 1'b1, 1'b1);
    drain(2);
    idle_chk();
    // sixteen two-byte reads fill the fifo to its depth; the next read must hold scl low
    for (i = 0; i < 16; i++) begin
      q = rnd();
      readback(addr_pin, q[1:0], 1'b0, q[2], 1'b1);
    end
    readback(addr_pin, q[4:3], 1'b0, 1'b0, 1'b0);
    repeat (2000) @(posedge clk);
    apb(1'b0, `DRI_REG_STATUS, 32'h0, q);
    chk("fifo_stall", 32'h5, q);
    chk("stall_scl", 32'h0, {31'h0, bus.scl});
    drain(32);
    wait_idle(q);
    chk("fifo_resume", 32'h4, q);
    drain(2);
    idle_chk();
    wrap_up();
  end
endmodule
